// ===== rtl/adc_seq_pkg.sv
// Shared constants and types for the converter control and status port.
// Assumes an 8-bit register port and a byte address space of 8 bits.
package adc_seq_pkg;

  // ==========================================================
  // Register offsets (byte addresses on the register port)
  // ==========================================================
  localparam logic [7:0] OFS_TEST1      = 8'h81; // Special channel test
  localparam logic [7:0] OFS_CTRL_TWO   = 8'h82; // Flag clear, trigger
  localparam logic [7:0] OFS_CTRL_THREE = 8'h83; // Length, queue mode
  localparam logic [7:0] OFS_CTRL_FOUR  = 8'h84; // Timing, abort only
  localparam logic [7:0] OFS_START      = 8'h85; // Sequence start
  localparam logic [7:0] OFS_STATUS     = 8'h86; // Sequence status
  localparam logic [7:0] OFS_COMPLETE   = 8'h8B; // Complete flags
  localparam logic [7:0] OFS_DIEN       = 8'h8D; // Digital input enable
  localparam logic [7:0] OFS_PORT       = 8'h8F; // Port input
  localparam logic [7:0] OFS_RESULT     = 8'h90; // First result byte
  localparam logic [3:0] RESULT_PAGE    = 4'h9;  // Upper nibble of results

  // ==========================================================
  // Field positions
  // ==========================================================
  // Status register
  localparam int ST_DONE     = 7;
  localparam int ST_TRIG_OVR = 5;
  localparam int ST_RES_OVR  = 4;
  // Start register
  localparam int SR_SCAN     = 5;
  localparam int SR_MULTI_CHANNEL_SEL     = 4;
  // Control two
  localparam int C2_FAST_CLR = 6;
  localparam int C2_TRIG_LVL = 4;
  localparam int C2_TRIG_EN  = 2;
  // Control three: length in bits 6..3, queue mode in bit 2
  localparam int C3_LEN_LSB  = 3;
  localparam int C3_QUEUE    = 2;
  // Test register
  localparam int T1_SPECIAL  = 0;

  // ==========================================================
  // Reset values and constants
  // ==========================================================
  localparam logic [7:0] RST_BYTE     = 8'h00;
  localparam logic [7:0] RST_PORT     = 8'hFF;
  localparam logic [2:0] CNT_ZERO     = 3'h0;
  localparam logic [2:0] CNT_ONE      = 3'h1;
  localparam logic [3:0] LEN_FULL     = 4'h8;
  localparam logic [9:0] RES_ZERO     = 10'h000;
  localparam logic [5:0] LOW_PAD      = 6'h00;

  // ==========================================================
  // Types
  // ==========================================================
  // Request handed to the analog sampling machine
  typedef struct packed {
    logic       special; // Route internal reference channels
    logic [2:0] channel; // Channel select code
  } conv_req_t;

  // Sequencer states
  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_ARMED,
    SEQ_ISSUE,
    SEQ_WAIT
  } seq_state_t;

endpackage : adc_seq_pkg

// ===== rtl/adc_sequence_status_port.sv
// Converter sequence control, status flags, results and digital port.
// Assumes a synchronous analog sampling machine that answers each start
// pulse with one done pulse and a 10-bit result, and an external trigger
// decoder that delivers one-cycle trigger pulses.
//
// The address-and-strobe port was decided locally.
module adc_sequence_status_port #(
  parameter int NUM_CH = 8   // Analog inputs and result registers
) (
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  // Register port
  input  wire logic [7:0]              reg_addr,
  input  wire logic [7:0]              reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output      logic [7:0]              reg_rdata,
  // Chip operating mode: high in special (test) modes
  input  wire logic                    special_mode,
  // Decoded external trigger, one pulse per active edge
  input  wire logic                    trigger_event,
  // Analog sampling machine
  output      logic                    conv_start,
  output      adc_seq_pkg::conv_req_t  conv_req,
  input  wire logic                    conv_done,
  input  wire logic [9:0]              conv_result,
  // Shared analog pins
  input  wire logic [NUM_CH-1:0]       analog_input_pin,
  output      logic [NUM_CH-1:0]       digital_buffer_enable
);

  // ==========================================================
  // Decoding helpers
  // ==========================================================
  // Address hit on a single register
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction : hit

  // Number of conversions per sequence; zero and above eight mean eight
  function automatic logic [3:0] seq_len(input logic [3:0] code);
    if (code == 4'h0 || code > adc_seq_pkg::LEN_FULL) begin
      seq_len = adc_seq_pkg::LEN_FULL;
    end else begin
      seq_len = code;
    end
  endfunction : seq_len

  // ==========================================================
  // Declarations
  // ==========================================================
  logic [7:0]              ctrl_two;         // Fast clear, trigger setup
  logic [7:0]              ctrl_three;       // Length and queue mode
  logic [7:0]              ctrl_four;        // Held only, no effect here
  logic [7:0]              start_reg;        // Scan, multi, select code
  logic [7:0]              test_reg;         // Special channel enable
  logic [NUM_CH-1:0]       ien;              // Digital buffer enables
  logic                    sequence_done_flag;
  logic                    trigger_overrun_flag;
  logic                    result_overrun_flag;
  logic [2:0]              conversion_counter;
  logic [NUM_CH-1:0]       conversion_complete_flag;
  logic [NUM_CH-1:0]       port_input_bit;   // Sampled port view
  logic [9:0]              result_reg [NUM_CH]; // Result storage
  logic                    flags_read_armed; // Complete flags were read
  adc_seq_pkg::seq_state_t state;
  logic [2:0]              cur_channel;      // Channel now converting
  logic [3:0]              position;         // Conversions done so far

  // Bus strobes decoded once
  logic wr_start, wr_ctl_other, wr_status, wr_complete, wr_test, wr_dien;
  logic rd_result, rd_complete;
  logic [2:0] rd_index;                      // Result register addressed

  // Control fields
  logic       fast_flag_clear, trigger_level_sel, trigger_enable;
  logic       queue_mode, scan_mode, multi_channel_sel;
  logic [3:0] sequence_length;
  logic [2:0] channel_select_code;

  // Sequencer events
  logic conv_accept;   // Result arrives for the running sequence
  logic seq_last;      // This result finishes the sequence
  logic [2:0] next_channel;

  assign wr_start     = reg_wr && hit(reg_addr, adc_seq_pkg::OFS_START);
  assign wr_ctl_other = reg_wr && (hit(reg_addr, adc_seq_pkg::OFS_CTRL_TWO)
                     || hit(reg_addr, adc_seq_pkg::OFS_CTRL_THREE)
                     || hit(reg_addr, adc_seq_pkg::OFS_CTRL_FOUR));
  assign wr_status    = reg_wr && hit(reg_addr, adc_seq_pkg::OFS_STATUS);
  assign wr_complete  = reg_wr && hit(reg_addr, adc_seq_pkg::OFS_COMPLETE);
  assign wr_test      = reg_wr && hit(reg_addr, adc_seq_pkg::OFS_TEST1);
  assign wr_dien      = reg_wr && hit(reg_addr, adc_seq_pkg::OFS_DIEN);
  assign rd_result    = reg_rd && (reg_addr[7:4] == adc_seq_pkg::RESULT_PAGE);
  assign rd_complete  = reg_rd && hit(reg_addr, adc_seq_pkg::OFS_COMPLETE);
  assign rd_index     = reg_addr[3:1];

  assign fast_flag_clear     = ctrl_two[adc_seq_pkg::C2_FAST_CLR];
  assign trigger_level_sel   = ctrl_two[adc_seq_pkg::C2_TRIG_LVL];
  assign trigger_enable      = ctrl_two[adc_seq_pkg::C2_TRIG_EN];
  assign sequence_length     = ctrl_three[adc_seq_pkg::C3_LEN_LSB +: 4];
  assign queue_mode          = ctrl_three[adc_seq_pkg::C3_QUEUE];
  assign scan_mode           = start_reg[adc_seq_pkg::SR_SCAN];
  assign multi_channel_sel   = start_reg[adc_seq_pkg::SR_MULTI_CHANNEL_SEL];
  assign channel_select_code = start_reg[2:0];

  assign conv_accept = (state == adc_seq_pkg::SEQ_WAIT) && conv_done
                    && !wr_start && !wr_ctl_other;
  assign seq_last    = ((position + 4'h1) == seq_len(sequence_length));

  assign next_channel = multi_channel_sel ? (cur_channel + 3'h1)
                                          : cur_channel;

  // ==========================================================
  // Control registers
  // ==========================================================
  // Plain read/write control bytes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_two   <= adc_seq_pkg::RST_BYTE;
      ctrl_three <= adc_seq_pkg::RST_BYTE;
      ctrl_four  <= adc_seq_pkg::RST_BYTE;
      start_reg  <= adc_seq_pkg::RST_BYTE;
      test_reg   <= adc_seq_pkg::RST_BYTE;
    end else if (reg_wr) begin
      // Upper test bits are stored as written; software keeps them zero
      if (hit(reg_addr, adc_seq_pkg::OFS_CTRL_TWO))   ctrl_two   <= reg_wdata;
      if (hit(reg_addr, adc_seq_pkg::OFS_CTRL_THREE)) ctrl_three <= reg_wdata;
      if (hit(reg_addr, adc_seq_pkg::OFS_CTRL_FOUR))  ctrl_four  <= reg_wdata;
      if (wr_start)                                   start_reg  <= reg_wdata;
      if (wr_test)                                    test_reg   <= reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ien <= '0;
    end else if (wr_dien) begin
      ien <= reg_wdata[NUM_CH-1:0];
    end
  end

  // ==========================================================
  // Sequencer
  // ==========================================================
  // Walks channels and positions; start writes restart from the new
  // settings, other control writes abort to idle.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state       <= adc_seq_pkg::SEQ_IDLE;
      cur_channel <= adc_seq_pkg::CNT_ZERO;
      position    <= '0;
    end else if (wr_start) begin
      cur_channel <= reg_wdata[2:0];
      position    <= '0;
      state       <= trigger_enable ? adc_seq_pkg::SEQ_ARMED
                                    : adc_seq_pkg::SEQ_ISSUE;
    end else if (wr_ctl_other) begin
      // Abort: nothing continues until the next start write
      state    <= adc_seq_pkg::SEQ_IDLE;
      position <= '0;
    end else begin
      case (state)
        adc_seq_pkg::SEQ_IDLE: begin
          state <= adc_seq_pkg::SEQ_IDLE;
        end
        adc_seq_pkg::SEQ_ARMED: begin
          // Wait for the trigger before each triggered sequence
          if (trigger_event) state <= adc_seq_pkg::SEQ_ISSUE;
        end
        adc_seq_pkg::SEQ_ISSUE: begin
          state <= adc_seq_pkg::SEQ_WAIT;
        end
        adc_seq_pkg::SEQ_WAIT: begin
          if (conv_accept) begin
            if (seq_last) begin
              position    <= '0;
              cur_channel <= channel_select_code;
              if (trigger_enable) begin
                state <= adc_seq_pkg::SEQ_ARMED;
              end else if (scan_mode) begin
                state <= adc_seq_pkg::SEQ_ISSUE;
              end else begin
                state <= adc_seq_pkg::SEQ_IDLE;
              end
            end else begin
              position    <= position + 4'h1;
              cur_channel <= next_channel;
              state       <= adc_seq_pkg::SEQ_ISSUE;
            end
          end
        end
        default: begin
          state <= adc_seq_pkg::SEQ_IDLE;
        end
      endcase
    end
  end

  // Start pulse and channel request toward the analog machine
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      conv_start <= 1'b0;
      conv_req   <= '0;
    end else begin
      conv_start <= (state == adc_seq_pkg::SEQ_ISSUE) && !wr_start
                 && !wr_ctl_other;
      conv_req.channel <= cur_channel;
      conv_req.special <= test_reg[adc_seq_pkg::T1_SPECIAL];
    end
  end

  // ==========================================================
  // Conversion counter and result storage
  // ==========================================================
  // counter not writable
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      conversion_counter <= adc_seq_pkg::CNT_ZERO;
    end else if (wr_start) begin
      if (!queue_mode) conversion_counter <= adc_seq_pkg::CNT_ZERO;
    end else if (conv_accept) begin
      if (seq_last && !queue_mode) begin
        conversion_counter <= adc_seq_pkg::CNT_ZERO;
      end else begin
        conversion_counter <= conversion_counter + adc_seq_pkg::CNT_ONE;
      end
    end
  end

  // Result words land in the register the counter points at
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_CH; i++) result_reg[i] <= adc_seq_pkg::RES_ZERO;
    end else if (conv_accept) begin
      result_reg[conversion_counter] <= conv_result;
    end
  end

  // ==========================================================
  // Status flags
  // ==========================================================
  // done each sequence
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sequence_done_flag <= 1'b0;
    end else if (conv_accept && seq_last) begin
      sequence_done_flag <= 1'b1;   // Set wins over any clear
    end else if (wr_start
              || (wr_status && reg_wdata[adc_seq_pkg::ST_DONE])
              || (rd_result && fast_flag_clear)) begin
      sequence_done_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trigger_overrun_flag <= 1'b0;
    end else if (trigger_event && trigger_enable && !trigger_level_sel
              && (state == adc_seq_pkg::SEQ_ISSUE
               || state == adc_seq_pkg::SEQ_WAIT)) begin
      trigger_overrun_flag <= 1'b1;
    end else if (wr_start || wr_ctl_other
              || (wr_status && reg_wdata[adc_seq_pkg::ST_TRIG_OVR])) begin
      trigger_overrun_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      result_overrun_flag <= 1'b0;
    end else if (conv_accept
              && conversion_complete_flag[conversion_counter]) begin
      result_overrun_flag <= 1'b1;
    end else if (wr_start
              || (wr_status && reg_wdata[adc_seq_pkg::ST_RES_OVR])) begin
      result_overrun_flag <= 1'b0;
    end
  end

  // A complete-flag read arms the two-step clear used without fast clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_read_armed <= 1'b0;
    end else if (wr_start) begin
      flags_read_armed <= 1'b0;
    end else if (rd_complete) begin
      flags_read_armed <= 1'b1;
    end else if (rd_result) begin
      flags_read_armed <= 1'b0;
    end
  end

  // One flag per position; each bit handled by its own generated process
  for (genvar n = 0; n < NUM_CH; n++) begin : g_ccf
    logic set_n;
    logic clr_n;
    assign set_n = conv_accept && (conversion_counter == 3'(n));
    assign clr_n = wr_start
                || (rd_result && (rd_index == 3'(n))
                    && (fast_flag_clear || flags_read_armed));
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        conversion_complete_flag[n] <= 1'b0;
      end else if (set_n) begin
        conversion_complete_flag[n] <= 1'b1;
      end else if (wr_complete && special_mode) begin
        conversion_complete_flag[n] <= reg_wdata[n];
      end else if (clr_n) begin
        conversion_complete_flag[n] <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Digital port
  // ==========================================================
  // pin or one
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      port_input_bit        <= adc_seq_pkg::RST_PORT[NUM_CH-1:0];
      digital_buffer_enable <= '0;
    end else begin
      port_input_bit        <= (analog_input_pin & ien) | ~ien;
      digital_buffer_enable <= ien;
    end
  end

  // ==========================================================
  // Read data
  // ==========================================================
  // Answer one cycle after the read strobe; unmapped reads give zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= adc_seq_pkg::RST_BYTE;
    end else if (reg_rd) begin
      if (rd_result) begin
        // Even address high byte, odd address low byte, left justified
        reg_rdata <= reg_addr[0]
                   ? {result_reg[rd_index][1:0], adc_seq_pkg::LOW_PAD}
                   : result_reg[rd_index][9:2];
      end else begin
        case (reg_addr)
          adc_seq_pkg::OFS_TEST1:      reg_rdata <= test_reg;
          adc_seq_pkg::OFS_CTRL_TWO:   reg_rdata <= ctrl_two;
          adc_seq_pkg::OFS_CTRL_THREE: reg_rdata <= ctrl_three;
          adc_seq_pkg::OFS_CTRL_FOUR:  reg_rdata <= ctrl_four;
          adc_seq_pkg::OFS_START:      reg_rdata <= start_reg;
          adc_seq_pkg::OFS_STATUS: begin
            reg_rdata <= {sequence_done_flag, 1'b0, trigger_overrun_flag,
                          result_overrun_flag, 1'b0, conversion_counter};
          end
          adc_seq_pkg::OFS_COMPLETE:   reg_rdata <= conversion_complete_flag;
          adc_seq_pkg::OFS_DIEN:       reg_rdata <= ien;
          adc_seq_pkg::OFS_PORT:       reg_rdata <= port_input_bit;
          default:                     reg_rdata <= adc_seq_pkg::RST_BYTE;
        endcase
      end
    end else begin
      reg_rdata <= adc_seq_pkg::RST_BYTE;
    end
  end

endmodule : adc_sequence_status_port

// ===== dv/adc_conv_model.sv
// Model of the analog sampling machine on the far side of the port.
// Assumes one start pulse per conversion, as the port issues them.
module adc_conv_model (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic                   conv_start,
  input  wire adc_seq_pkg::conv_req_t conv_req,
  input  wire logic                   slow,
  output      logic                   conv_done,
  output      logic [9:0]             conv_result
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       busy;     // Conversion under way
  logic [1:0] wait_cnt; // Extra cycles before answering
  // ==========================================================
  // Answer: the result carries the request so channels differ;
  // between answers the word toggles so nothing stale looks valid
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy        <= 1'b0;
      wait_cnt    <= 2'h0;
      conv_done   <= 1'b0;
      conv_result <= 10'h155;
    end else if (conv_start) begin
      busy        <= 1'b1;
      wait_cnt    <= slow ? 2'h3 : 2'h0;
      conv_done   <= 1'b0;
      conv_result <= ~conv_result;
    end else if (busy && wait_cnt == 2'h0) begin
      busy        <= 1'b0;
      conv_done   <= 1'b1;
      conv_result <= {conv_req, 6'h2A};
    end else begin
      wait_cnt    <= wait_cnt - 2'h1;
      conv_done   <= 1'b0;
      conv_result <= ~conv_result;
    end
  end
endmodule : adc_conv_model

// ===== dv/adc_seq_chk.sv
// Checker on the pins of the converter control port.
// Assumes trigger enable is changed only by control-two writes seen here.
module adc_seq_chk #(
  parameter int NUM_CH = 8
) (
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic [7:0]        reg_addr,
  input wire logic [7:0]        reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [7:0]        reg_rdata,
  input wire logic              conv_start,
  input wire logic              conv_done,
  input wire logic              trigger_event,
  input wire logic [NUM_CH-1:0] analog_input_pin,
  input wire logic [NUM_CH-1:0] digital_buffer_enable
);
  timeunit 1ns;
  timeprecision 1ns;
  logic trig_en; // Shadow of the trigger enable control bit
  // Armed starts wait for a trigger, so they issue later than plain ones
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trig_en <= 1'b0;
    end else if (reg_wr && reg_addr == adc_seq_pkg::OFS_CTRL_TWO) begin
      trig_en <= reg_wdata[adc_seq_pkg::C2_TRIG_EN];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // Sequences
  sequence start_wr;
    reg_wr && reg_addr == adc_seq_pkg::OFS_START && !trig_en;
  endsequence
  sequence issue_s;
    !conv_start ##1 conv_start;
  endsequence
  // ==========================================================
  // Properties
  // start write restarts
  start_issue_a: assert property (start_wr |=> issue_s)
    else $error("no conversion after start write");
  single_pulse_a: assert property (conv_start |=> !conv_start [*2])
    else $error("start pulse too long or too close");
  cause_start_a: assert property (conv_start |-> $past(conv_done, 2)
    || $past(trigger_event, 2)
    || ($past(reg_wr, 2) && $past(reg_addr, 2) == adc_seq_pkg::OFS_START))
    else $error("conversion issued without cause");
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside a read");
  port_read_a: assert property (reg_rd && reg_addr == adc_seq_pkg::OFS_PORT
    |=> reg_rdata == ($past(analog_input_pin, 2)
                      | ~$past(digital_buffer_enable)))
    else $error("port read wrong");
  status_zero_a: assert property (reg_rd && reg_addr == adc_seq_pkg::OFS_STATUS
    |=> reg_rdata[6] == 1'b0 && reg_rdata[3] == 1'b0)
    else $error("unused status bits set");
  dien_copy_a: assert property (reg_wr && reg_addr == adc_seq_pkg::OFS_DIEN
    ##2 1'b1 |-> digital_buffer_enable == $past(reg_wdata, 2))
    else $error("buffer enables not written");
  reset_quiet_a: assert property ($rose(rst_n) |-> !conv_start
    && digital_buffer_enable == 8'h00)
    else $error("outputs active after reset");
endmodule : adc_seq_chk

bind adc_sequence_status_port adc_seq_chk #(.NUM_CH(NUM_CH)) chk_u (
  .clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .conv_start, .conv_done, .trigger_event, .analog_input_pin,
  .digital_buffer_enable);

// ===== dv/adc_sequence_status_port_tb.sv
// Self-checking bench for the converter control and status port.
// Assumes the conversion model and the bound checker beside it.
module adc_sequence_status_port_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic                   clk, rst_n, reg_wr, reg_rd, special_mode;
  logic                   slow, conv_start, conv_done, trig;
  logic [7:0]             reg_addr, reg_wdata, reg_rdata, pins, dben, rdv;
  logic [9:0]             conv_result;
  adc_seq_pkg::conv_req_t conv_req;
  logic [3:0]             reqs[$]; // Requests issued, oldest first
  int                     errors, checks, cycles;
  adc_sequence_status_port dut_u (.clk, .rst_n, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .special_mode, .trigger_event(trig),
    .conv_start, .conv_req, .conv_done, .conv_result,
    .analog_input_pin(pins), .digital_buffer_enable(dben));
  adc_conv_model model_u (.clk, .rst_n, .conv_start, .conv_req, .slow,
    .conv_done, .conv_result);
  // ==========================================================
  // Clock, request log and hang guard
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (conv_start) reqs.push_back(conv_req);
    if (cycles == 20000) begin
      errors++;
      stop_test();
    end
  end
  // ==========================================================
  // Tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] m,
                    input logic [7:0] e);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    rdv = reg_rdata;
    chk(rdv & m, e);
  endtask : rd
  // Polls the done flag under a bound; polls are not counted as checks
  task automatic wait_done;
    int n;
    n = 0;
    rdv = 8'h00;
    while (!rdv[7] && n < 100) begin
      rd(adc_seq_pkg::OFS_STATUS, 8'h00, 8'h00);
      checks--;
      n++;
    end
    chk(rdv & 8'h80, 8'h80);
  endtask : wait_done
  task automatic chk_reqs(input logic [3:0] e[$]);
    chk(8'(reqs.size()), 8'(e.size()));
    foreach (e[i]) chk({4'h0, reqs[i]}, {4'h0, e[i]});
    reqs.delete();
  endtask : chk_reqs
  task automatic stop_test;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : stop_test
  // ==========================================================
  // Main sequence
  initial begin
    {rst_n, reg_wr, reg_rd, special_mode, slow, trig} = 6'h00;
    {reg_addr, reg_wdata, pins} = {16'h0000, 8'hA5};
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rd(adc_seq_pkg::OFS_STATUS, 8'hFF, 8'h00);
    rd(adc_seq_pkg::OFS_PORT, 8'hFF, 8'hFF);
    rd(8'h80, 8'hFF, 8'h00);
    wr(adc_seq_pkg::OFS_DIEN, 8'h0F);
    rd(adc_seq_pkg::OFS_PORT, 8'hFF, 8'hF5);
    wr(adc_seq_pkg::OFS_PORT, 8'h00);
    pins <= 8'h5A;
    rd(adc_seq_pkg::OFS_PORT, 8'hFF, 8'hFA);
    $display("test ports done");
    // Single channel, then multi with wrap
    wr(adc_seq_pkg::OFS_CTRL_THREE, 8'h10);
    wr(adc_seq_pkg::OFS_START, 8'h03);
    wait_done();
    chk_reqs('{4'h3, 4'h3});
    rd(adc_seq_pkg::OFS_COMPLETE, 8'hFF, 8'h03);
    rd(8'h90, 8'hFF, 8'h3A);
    rd(adc_seq_pkg::OFS_COMPLETE, 8'hFF, 8'h02);
    wr(adc_seq_pkg::OFS_CTRL_THREE, 8'h18);
    wr(adc_seq_pkg::OFS_START, 8'h16);
    rd(adc_seq_pkg::OFS_STATUS, 8'h80, 8'h00);
    wait_done();
    chk_reqs('{4'h6, 4'h7, 4'h0});
    rd(adc_seq_pkg::OFS_STATUS, 8'hFF, 8'h80);
    rd(8'h94, 8'hFF, 8'h0A);
    $display("test channels done");
    // Continuous single runs overwrite result zero
    wr(adc_seq_pkg::OFS_CTRL_THREE, 8'h08);
    wr(adc_seq_pkg::OFS_START, 8'h21);
    wait_done();
    wr(adc_seq_pkg::OFS_STATUS, 8'h80);
    wait_done();
    wr(adc_seq_pkg::OFS_CTRL_TWO, 8'h00);
    rd(adc_seq_pkg::OFS_STATUS, 8'hF0, 8'h90);
    wr(adc_seq_pkg::OFS_STATUS, 8'h00);
    rd(adc_seq_pkg::OFS_STATUS, 8'hF0, 8'h90);
    wr(adc_seq_pkg::OFS_STATUS, 8'h90);
    rd(adc_seq_pkg::OFS_STATUS, 8'hF0, 8'h00);
    reqs.delete();
    $display("test flags done");
    // Fast clear, then a reference channel
    wr(adc_seq_pkg::OFS_CTRL_TWO, 8'h40);
    wr(adc_seq_pkg::OFS_START, 8'h05);
    wait_done();
    rd(8'h91, 8'hFF, 8'h80);
    rd(adc_seq_pkg::OFS_STATUS, 8'hF0, 8'h00);
    rd(adc_seq_pkg::OFS_COMPLETE, 8'hFF, 8'h00);
    wr(adc_seq_pkg::OFS_TEST1, 8'h01);
    wr(adc_seq_pkg::OFS_START, 8'h04);
    wait_done();
    rd(8'h90, 8'hFF, 8'hCA);
    chk_reqs('{4'h5, 4'hC});
    wr(adc_seq_pkg::OFS_TEST1, 8'h00);
    wr(adc_seq_pkg::OFS_COMPLETE, 8'hFF);
    rd(adc_seq_pkg::OFS_COMPLETE, 8'hFF, 8'h00);
    special_mode <= 1'b1;
    wr(adc_seq_pkg::OFS_COMPLETE, 8'h81);
    rd(adc_seq_pkg::OFS_COMPLETE, 8'hFF, 8'h81);
    special_mode <= 1'b0;
    $display("test clears done");
    // Queue mode with a slow partner keeps counting and rolls over
    slow <= 1'b1;
    wr(adc_seq_pkg::OFS_CTRL_THREE, 8'h0C);
    wr(adc_seq_pkg::OFS_START, 8'h02);
    wait_done();
    rd(adc_seq_pkg::OFS_STATUS, 8'hFF, 8'h81);
    wr(adc_seq_pkg::OFS_CTRL_THREE, 8'h44);
    wr(adc_seq_pkg::OFS_START, 8'h02);
    wait_done();
    rd(adc_seq_pkg::OFS_STATUS, 8'hFF, 8'h81);
    $display("test queue done");
    // Edge trigger: a second edge while converting is an overrun
    wr(adc_seq_pkg::OFS_CTRL_TWO, 8'h04);
    wr(adc_seq_pkg::OFS_START, 8'h00);
    repeat (2) begin
      @(posedge clk);
      trig <= 1'b1;
    end
    @(posedge clk);
    trig <= 1'b0;
    rd(adc_seq_pkg::OFS_STATUS, 8'h20, 8'h20);
    wr(adc_seq_pkg::OFS_CTRL_FOUR, 8'h00);
    rd(adc_seq_pkg::OFS_STATUS, 8'h20, 8'h00);
    $display("test trigger done");
    stop_test();
  end
endmodule : adc_sequence_status_port_tb
